// File: rtl/sfer_cal_seq.v
// Calibration sequence tracker for program and readback calibration.
// Assumes commands arrive as one-cycle strobes from the command parser.
`include "sfer_regs.vh"

module sfer_cal_seq #(
  parameter DW = 16
) (
  input  wire          clk,
  input  wire          nrst,
  input  wire          cmd_stb,
  input  wire [2:0]    cmd_sel,
  input  wire [DW-1:0] val_lo,
  input  wire [DW-1:0] val_hi,
  output reg  [DW-1:0] const_lo_q,
  output reg  [DW-1:0] const_hi_q,
  output reg           store_q,
  output reg           order_err_q
);

  reg [2:0] prog_q;
  reg [2:0] rb_q;
  reg       is_rb;

  always @* begin
    is_rb = (cmd_sel == `SFER_C_RLOW) || (cmd_sel == `SFER_C_RHIGH) ||
            (cmd_sel == `SFER_C_RDATA);
  end

  // An out-of-order step restarts its sequence and flags it
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prog_q      <= `SFER_S_IDLE;
      rb_q        <= `SFER_S_IDLE;
      const_lo_q  <= {DW{1'b0}};
      const_hi_q  <= {DW{1'b0}};
      store_q     <= 1'b0;
      order_err_q <= 1'b0;
    end else begin
      store_q     <= 1'b0;
      order_err_q <= 1'b0;
      if (cmd_stb && !is_rb) begin
        case (cmd_sel)
          `SFER_C_PLOW: prog_q <= `SFER_S_LOW;
          `SFER_C_PHIGH: begin
            if (prog_q == `SFER_S_LOW) begin
              prog_q <= `SFER_S_HIGH;
            end else begin
              prog_q      <= `SFER_S_IDLE;
              order_err_q <= 1'b1;
            end
          end
          default: begin
            if (prog_q == `SFER_S_HIGH) begin
              const_lo_q <= val_lo;
              const_hi_q <= val_hi;
              store_q    <= 1'b1;
            end else begin
              order_err_q <= 1'b1;
            end
            prog_q <= `SFER_S_IDLE;
          end
        endcase
      end else if (cmd_stb) begin
        case (rb_q)
          `SFER_S_IDLE: begin
            if (cmd_sel == `SFER_C_RLOW) begin
              rb_q <= `SFER_S_RLOW1;
            end else begin
              order_err_q <= 1'b1;
            end
          end
          `SFER_S_RLOW1: begin
            if (cmd_sel == `SFER_C_RLOW) begin
              rb_q <= `SFER_S_RLOW2;
            end else begin
              rb_q        <= `SFER_S_IDLE;
              order_err_q <= 1'b1;
            end
          end
          `SFER_S_RLOW2: begin
            if (cmd_sel == `SFER_C_RHIGH) begin
              rb_q <= `SFER_S_RHIGH1;
            end else begin
              rb_q        <= `SFER_S_IDLE;
              order_err_q <= 1'b1;
            end
          end
          `SFER_S_RHIGH1: begin
            if (cmd_sel == `SFER_C_RHIGH) begin
              rb_q <= `SFER_S_RHIGH2;
            end else begin
              rb_q        <= `SFER_S_IDLE;
              order_err_q <= 1'b1;
            end
          end
          default: begin
            if (cmd_sel == `SFER_C_RDATA) begin
              // Offsets stored as the measured points; slope math is firmware
              const_lo_q <= val_lo;
              const_hi_q <= val_hi;
              store_q    <= 1'b1;
            end else begin
              order_err_q <= 1'b1;
            end
            rb_q <= `SFER_S_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// File: rtl/sfer_status.v
// Status, latched status, fault registers, error latch and calibration gate.
// Assumes a command parser on CLK issues one-cycle query and event strobes;
// condition levels arrive asynchronously from the supply.
//
// Function
// - Latched status, live status and fault registers are always active.
// - A query answers the weighted sum of set conditions in that register.
// - Overvoltage trip is bit 3 weight 8; overtemperature bit 4 weight 16.
// - External shutdown is bit 5 weight 32.
// - Power-on is bit 8 weight 256, absent from fault register.
// - Remote mode is bit 9 weight 512, absent from fault register.
// - Error-number query clears error bit in latched, live and poll registers.
// - Latched status query clears that register after the reply.
// - Fault query clears the recorded faults.
// - Every condition bit can be masked and unmasked individually.
// - Error-number query returns latched code and clears flag; 0 is none.
// - Syntax-class faults record code 4.
// - Out-of-range parameter records code 5.
// - Exceeding soft limit records code 6 and refuses the setting.
// - Soft limit below present output records code 7.
// - Data requested without pending query records code 8.
// - Overvoltage level below present output records code 9.
// - Secondary processor not responding records code 10.
// - Calibration while calibration mode off is refused with code 12.
// - Program calibration: low, high, then data; constants stored.
// - Readback calibration: low twice, high twice, then data; offsets stored.
`include "sfer_regs.vh"

module sfer_status #(
  parameter DW = 16
) (
  // Clock and reset
  input  wire          CLK,
  input  wire          NRST,
  // Supply condition levels, asynchronous
  input  wire          CONST_VOLT_FLAG,
  input  wire          CONST_CURR_FLAG,
  input  wire          OVERVOLTAGE_TRIP_FLAG,
  input  wire          OVERTEMP_TRIP_FLAG,
  input  wire          EXT_SHUTDOWN_FLAG,
  input  wire          FOLDBACK_FLAG,
  input  wire          POWER_ON_FLAG,
  input  wire          REMOTE_MODE_FLAG,
  input  wire          MAINS_FAIL_FLAG,
  input  wire          OUTPUT_FAIL_FLAG,
  input  wire          SENSE_TRIP_FLAG,
  // Condition mask, one bit per condition, 1 enables
  input  wire [12:0]   COND_MASK,
  // Query request and reply
  input  wire          QUERY_STB,
  input  wire [2:0]    QUERY_SEL,
  output reg  [12:0]   REPLY_DATA,
  output reg           REPLY_VALID,
  // Command fault events
  input  wire          FAULT_EVT_STB,
  input  wire [2:0]    FAULT_EVT_SEL,
  // Setting requests checked against soft limit
  input  wire          SET_STB,
  input  wire          SET_OVER_LIMIT,
  output reg           SET_ACCEPT,
  // Calibration mode and commands
  input  wire          CAL_MODE_STB,
  input  wire          CAL_MODE_VAL,
  input  wire          CAL_CMD_STB,
  input  wire [2:0]    CAL_CMD_SEL,
  input  wire [DW-1:0] CAL_VAL_LO,
  input  wire [DW-1:0] CAL_VAL_HI,
  output reg           CAL_MODE,
  output reg  [DW-1:0] CAL_CONST_LO,
  output reg  [DW-1:0] CAL_CONST_HI,
  output reg           CAL_STORED,
  // Serial poll error bit and live status view
  output reg           POLL_ERR,
  output reg  [12:0]   LIVE_STATUS
);

  wire [12:0] cond_raw;
  wire [12:0] cond_s;
  wire [DW-1:0] cs_lo;
  wire [DW-1:0] cs_hi;
  wire        cs_store;
  wire        cs_order;

  reg  [12:0] latched_q;
  reg  [12:0] live_q;
  reg  [12:0] fault_q;
  reg  [3:0]  err_code_q;
  reg         err_flag_q;
  reg         cal_mode_q;
  reg  [3:0]  evt_code;
  reg         evt_err;
  reg  [12:0] cond_m;
  reg  [12:0] err_vec;
  reg         err_clr;

  assign cond_raw[`SFER_B_CV]     = CONST_VOLT_FLAG;
  assign cond_raw[`SFER_B_CC]     = CONST_CURR_FLAG;
  assign cond_raw[`SFER_B_UNUSED] = 1'b0;
  assign cond_raw[`SFER_B_OV]     = OVERVOLTAGE_TRIP_FLAG;
  assign cond_raw[`SFER_B_OT]     = OVERTEMP_TRIP_FLAG;
  assign cond_raw[`SFER_B_SD]     = EXT_SHUTDOWN_FLAG;
  assign cond_raw[`SFER_B_FOLDBACK_FLAG]   = FOLDBACK_FLAG;
  assign cond_raw[`SFER_B_ERR]    = 1'b0;
  assign cond_raw[`SFER_B_PON]    = POWER_ON_FLAG;
  assign cond_raw[`SFER_B_REM]    = REMOTE_MODE_FLAG;
  assign cond_raw[`SFER_B_ACF]    = MAINS_FAIL_FLAG;
  assign cond_raw[`SFER_B_OPF]    = OUTPUT_FAIL_FLAG;
  assign cond_raw[`SFER_B_SNS]    = SENSE_TRIP_FLAG;

  sfer_sync #(
    .W (`SFER_W)
  ) u_sync (
    .clk  (CLK),
    .nrst (NRST),
    .d    (cond_raw),
    .q    (cond_s)
  );

  sfer_cal_seq #(
    .DW (DW)
  ) u_cal (
    .clk         (CLK),
    .nrst        (NRST),
    .cmd_stb     (CAL_CMD_STB && cal_mode_q),
    .cmd_sel     (CAL_CMD_SEL),
    .val_lo      (CAL_VAL_LO),
    .val_hi      (CAL_VAL_HI),
    .const_lo_q  (cs_lo),
    .const_hi_q  (cs_hi),
    .store_q     (cs_store),
    .order_err_q (cs_order)
  );

  // Error event decode; of events in one cycle, the first in this chain sets the code
  always @* begin
    evt_err  = 1'b0;
    evt_code = `SFER_E_NONE;
    if (CAL_CMD_STB && !cal_mode_q) begin
      evt_err  = 1'b1;
      evt_code = `SFER_E_ILLCAL;
    end else if (SET_STB && SET_OVER_LIMIT) begin
      evt_err  = 1'b1;
      evt_code = `SFER_E_SOFTLIM;
    end else if (QUERY_STB && QUERY_SEL == `SFER_Q_NONE) begin
      evt_err  = 1'b1;
      evt_code = `SFER_E_NOQUERY;
    end else if (cs_order) begin
      evt_err  = 1'b1;
      evt_code = `SFER_E_SYNTAX;
    end else if (FAULT_EVT_STB) begin
      evt_err = 1'b1;
      case (FAULT_EVT_SEL)
        `SFER_EV_SYNTAX:  evt_code = `SFER_E_SYNTAX;
        `SFER_EV_RANGE:   evt_code = `SFER_E_RANGE;
        `SFER_EV_SOFTLIM: evt_code = `SFER_E_SOFTLIM;
        `SFER_EV_BADLIM:  evt_code = `SFER_E_BADLIM;
        `SFER_EV_NOQUERY: evt_code = `SFER_E_NOQUERY;
        `SFER_EV_OVPLOW:  evt_code = `SFER_E_OVPLOW;
        `SFER_EV_SLAVE:   evt_code = `SFER_E_SLAVE;
        default:          evt_code = `SFER_E_SYNTAX;
      endcase
    end
  end

  // Mask and clear terms shared by the live, latched, fault, error, reply and poll registers below
  always @* begin
    err_clr = QUERY_STB && (QUERY_SEL == `SFER_Q_ERRNUM);
    cond_m  = cond_s & COND_MASK;
    err_vec = `SFER_ZERO13;
    err_vec[`SFER_B_ERR] = err_flag_q && COND_MASK[`SFER_B_ERR];
  end

  // Live view trails the synchroniser by one cycle
  // It feeds both the live query and the live status port
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      live_q <= `SFER_ZERO13;
    end else begin
      live_q <= cond_m | err_vec;
    end
  end

  // Error flag and code: a new error wins over the clearing query,
  // so an error raised while the host reads the old one is not lost
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      err_flag_q <= 1'b0;
      err_code_q <= `SFER_E_NONE;
    end else if (evt_err) begin
      err_flag_q <= 1'b1;
      err_code_q <= evt_code;
    end else if (err_clr) begin
      err_flag_q <= 1'b0;
      err_code_q <= `SFER_E_NONE;
    end
  end

  // Read-clear reloads conditions still present so none is lost.
  // The error query drops the error bit even if it is masked now.
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      latched_q <= `SFER_ZERO13;
    end else if (QUERY_STB && QUERY_SEL == `SFER_Q_LATCHED) begin
      latched_q <= cond_m | err_vec;
    end else if (err_clr) begin
      latched_q              <= latched_q | cond_m;
      latched_q[`SFER_B_ERR] <= 1'b0;
    end else begin
      latched_q <= latched_q | cond_m | err_vec;
    end
  end

  // Fault record; power-on and remote are never accumulated here
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      fault_q <= `SFER_ZERO13;
    end else if (QUERY_STB && QUERY_SEL == `SFER_Q_FAULT) begin
      fault_q <= cond_m & ~`SFER_FAULT_EXCL;
    end else begin
      fault_q <= (fault_q | cond_m) & ~`SFER_FAULT_EXCL;
    end
  end

  // Reply formed from values before the clear
  // Data holds until the next query, so the host may read it late
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      REPLY_VALID <= 1'b0;
      REPLY_DATA  <= `SFER_ZERO13;
    end else begin
      REPLY_VALID <= QUERY_STB && (QUERY_SEL != `SFER_Q_NONE);
      if (QUERY_STB) begin
        if (QUERY_SEL == `SFER_Q_LATCHED) begin
          REPLY_DATA <= latched_q | cond_m | err_vec;
        end else if (QUERY_SEL == `SFER_Q_LIVE) begin
          REPLY_DATA <= live_q;
        end else if (QUERY_SEL == `SFER_Q_FAULT) begin
          REPLY_DATA <= fault_q | (cond_m & ~`SFER_FAULT_EXCL);
        end else if (QUERY_SEL == `SFER_Q_ERRNUM) begin
          REPLY_DATA <= {9'h000, err_flag_q ? err_code_q : `SFER_E_NONE};
        end
      end
    end
  end

  // Setting handshake; an over-limit value is refused, never applied
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      SET_ACCEPT <= 1'b0;
    end else begin
      SET_ACCEPT <= SET_STB && !SET_OVER_LIMIT;
    end
  end

  // Calibration gate; the sequencer sees strobes only while it is on.
  // The output copy keeps the top-level port straight from a flop.
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cal_mode_q <= 1'b0;
      CAL_MODE   <= 1'b0;
    end else if (CAL_MODE_STB) begin
      cal_mode_q <= CAL_MODE_VAL;
      CAL_MODE   <= CAL_MODE_VAL;
    end
  end

  // Stored constants pass one more stage so the ports stay registered
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      CAL_CONST_LO <= {DW{1'b0}};
      CAL_CONST_HI <= {DW{1'b0}};
    end else begin
      CAL_CONST_LO <= cs_lo;
      CAL_CONST_HI <= cs_hi;
    end
  end

  // Store pulse trails the data command by two cycles
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      CAL_STORED <= 1'b0;
    end else begin
      CAL_STORED <= cs_store;
    end
  end

  // Poll bit shows a new error at once and drops with the error query
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      POLL_ERR <= 1'b0;
    end else begin
      POLL_ERR <= evt_err || (err_flag_q && !err_clr);
    end
  end

  // Live status port, one cycle behind the live register
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      LIVE_STATUS <= `SFER_ZERO13;
    end else begin
      LIVE_STATUS <= live_q;
    end
  end

endmodule

// File: rtl/sfer_sync.v
// Two-stage synchroniser for a bundle of condition levels.
// Assumes inputs are levels from outside the CLK domain.
`include "sfer_regs.vh"

module sfer_sync #(
  parameter W = 13
) (
  input  wire         clk,
  input  wire         nrst,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta_q;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// File: shared/sfer_regs.vh
// Constants for the status, fault and error reporting block.
// Included by every design file of the block; definitions only.
`ifndef SFER_REGS_VH
`define SFER_REGS_VH

`define SFER_W          13
// Condition bit positions
`define SFER_B_CV       0
`define SFER_B_CC       1
`define SFER_B_UNUSED   2
`define SFER_B_OV       3
`define SFER_B_OT       4
`define SFER_B_SD       5
`define SFER_B_FOLDBACK_FLAG     6
`define SFER_B_ERR      7
`define SFER_B_PON      8
`define SFER_B_REM      9
`define SFER_B_ACF      10
`define SFER_B_OPF      11
`define SFER_B_SNS      12
// Bits that never appear in the fault register (power on, remote)
`define SFER_FAULT_EXCL 13'h0300
`define SFER_ZERO13     13'h0000
`define SFER_ONES13     13'h1FFF
// Query selectors
`define SFER_Q_LATCHED  3'h0
`define SFER_Q_LIVE     3'h1
`define SFER_Q_FAULT    3'h2
`define SFER_Q_ERRNUM   3'h3
`define SFER_Q_NONE     3'h4
// Error codes
`define SFER_E_NONE     4'h0
`define SFER_E_SYNTAX   4'h4
`define SFER_E_RANGE    4'h5
`define SFER_E_SOFTLIM  4'h6
`define SFER_E_BADLIM   4'h7
`define SFER_E_NOQUERY  4'h8
`define SFER_E_OVPLOW   4'h9
`define SFER_E_SLAVE    4'hA
`define SFER_E_ILLCAL   4'hC
// Fault event selectors
`define SFER_EV_SYNTAX  3'h0
`define SFER_EV_RANGE   3'h1
`define SFER_EV_SOFTLIM 3'h2
`define SFER_EV_BADLIM  3'h3
`define SFER_EV_NOQUERY 3'h4
`define SFER_EV_OVPLOW  3'h5
`define SFER_EV_SLAVE   3'h6
// Calibration commands
`define SFER_C_PLOW     3'h0
`define SFER_C_PHIGH    3'h1
`define SFER_C_PDATA    3'h2
`define SFER_C_RLOW     3'h3
`define SFER_C_RHIGH    3'h4
`define SFER_C_RDATA    3'h5
// Calibration sequence states
`define SFER_S_IDLE     3'h0
`define SFER_S_LOW      3'h1
`define SFER_S_HIGH     3'h2
`define SFER_S_RLOW1    3'h1
`define SFER_S_RLOW2    3'h2
`define SFER_S_RHIGH1   3'h3
`define SFER_S_RHIGH2   3'h4

`endif

// File: testbench/sfer_host.sv
// Host controller model: every request is a one-edge strobe.
// Assumes the block answers on the edge that takes the strobe.
module sfer_host (
  // Answers
  input  wire logic        clk,
  input  wire logic        rvalid,
  input  wire logic        stored,
  // Requests
  output logic             q_stb,
  output logic [2:0]       q_sel,
  output logic             e_stb,
  output logic [2:0]       e_sel,
  output logic             s_stb,
  output logic             s_over,
  output logic             m_stb,
  output logic             m_val,
  output logic             c_stb,
  output logic [2:0]       c_sel,
  output logic [15:0]      c_lo,
  output logic [15:0]      c_hi
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hung;
  initial begin
    {q_stb, q_sel, e_stb, e_sel, s_stb, s_over, hung} = '0;
    {m_stb, m_val, c_stb, c_sel, c_lo, c_hi} = '0;
  end
  // Selector 4 asks for data with nothing pending, so no reply is awaited
  task automatic query(input logic [2:0] sel);
    int n;
    @(negedge clk);
    q_sel = sel;
    q_stb = 1'b1;
    @(negedge clk);
    q_stb = 1'b0;
    n = 0;
    while (sel < 3'h4 && rvalid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    hung = (sel < 3'h4) && (rvalid !== 1'b1);
  endtask
  task automatic event_req(input logic [2:0] sel);
    @(negedge clk);
    e_sel = sel;
    e_stb = 1'b1;
    @(negedge clk);
    e_stb = 1'b0;
  endtask
  task automatic setting(input logic over);
    @(negedge clk);
    s_over = over;
    s_stb = 1'b1;
    @(negedge clk);
    s_stb = 1'b0;
  endtask
  task automatic cal_mode(input logic on);
    @(negedge clk);
    m_val = on;
    m_stb = 1'b1;
    @(negedge clk);
    m_stb = 1'b0;
  endtask
  task automatic cal(input logic [2:0] sel, input logic [15:0] lo, hi,
                     output logic ok);
    @(negedge clk);
    c_sel = sel;
    c_lo = lo;
    c_hi = hi;
    c_stb = 1'b1;
    @(negedge clk);
    c_stb = 1'b0;
    ok = 1'b0;
    repeat (3) begin
      ok = ok | (stored === 1'b1);
      @(negedge clk);
    end
  endtask
  // Low point, high point, then the measured pair
  task automatic prog_cal(input logic [15:0] lo, hi, output logic ok);
    cal(3'h0, lo, hi, ok);
    cal(3'h1, lo, hi, ok);
    cal(3'h2, lo, hi, ok);
  endtask
  // Each point twice, around settling, then the measured pair
  task automatic rb_cal(input logic [15:0] lo, hi, output logic ok);
    cal(3'h3, lo, hi, ok);
    cal(3'h3, lo, hi, ok);
    cal(3'h4, lo, hi, ok);
    cal(3'h4, lo, hi, ok);
    cal(3'h5, lo, hi, ok);
  endtask
endmodule

// File: testbench/sfer_status_assertions.sv
// Port checker for the status block, bound to its top module.
// Assumes one clock domain and the asynchronous active-low reset.
module sfer_status_chk (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        NRST,
  // Conditions and queries
  input wire logic        OVERVOLTAGE_TRIP_FLAG,
  input wire logic [12:0] COND_MASK,
  input wire logic        QUERY_STB,
  input wire logic [2:0]  QUERY_SEL,
  input wire logic [12:0] REPLY_DATA,
  input wire logic        REPLY_VALID,
  // Commands and answers
  input wire logic        FAULT_EVT_STB,
  input wire logic        SET_STB,
  input wire logic        SET_OVER_LIMIT,
  input wire logic        SET_ACCEPT,
  input wire logic        CAL_CMD_STB,
  input wire logic        CAL_MODE,
  input wire logic        CAL_STORED,
  input wire logic        POLL_ERR,
  input wire logic [12:0] LIVE_STATUS
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  AST_REPLY: assert property (QUERY_STB && QUERY_SEL < 3'h4 |=> REPLY_VALID)
    else $error("query not answered");
  AST_NO_REPLY: assert property (!QUERY_STB |=> !REPLY_VALID)
    else $error("reply without query");
  AST_FAULT_EXCL: assert property (QUERY_STB && QUERY_SEL == 3'h2 |=> REPLY_DATA[9:8] == 2'b00)
    else $error("power-on or remote in fault reply");
  AST_BIT2: assert property (QUERY_STB && QUERY_SEL < 3'h3 |=> !REPLY_DATA[2] && !LIVE_STATUS[2])
    else $error("unused bit set");
  AST_ERR_SET: assert property (FAULT_EVT_STB && COND_MASK[7] |=> POLL_ERR)
    else $error("error flag not raised");
  AST_ERR_CLR: assert property (QUERY_STB && QUERY_SEL == 3'h3 && !FAULT_EVT_STB && !SET_STB && !CAL_CMD_STB |=> !POLL_ERR ##2 !LIVE_STATUS[7])
    else $error("error flag not cleared");
  AST_SET_OK: assert property (SET_STB && !SET_OVER_LIMIT |=> SET_ACCEPT)
    else $error("legal setting refused");
  AST_SET_REF: assert property (SET_STB && SET_OVER_LIMIT |=> !SET_ACCEPT)
    else $error("over-limit setting taken");
  AST_CAL_REF: assert property (CAL_CMD_STB && !CAL_MODE |=> !CAL_STORED [*2])
    else $error("calibration stored outside mode");
  AST_LIVE_ON: assert property ((OVERVOLTAGE_TRIP_FLAG && COND_MASK[3]) [*4] |=> LIVE_STATUS[3])
    else $error("overvoltage trip missing");
  AST_LIVE_MASK: assert property ((!COND_MASK[3]) [*4] |=> !LIVE_STATUS[3])
    else $error("masked bit shown");
endmodule

bind sfer_status sfer_status_chk u_chk (
  .CLK(CLK), .NRST(NRST), .OVERVOLTAGE_TRIP_FLAG(OVERVOLTAGE_TRIP_FLAG),
  .COND_MASK(COND_MASK), .QUERY_STB(QUERY_STB), .QUERY_SEL(QUERY_SEL),
  .REPLY_DATA(REPLY_DATA), .REPLY_VALID(REPLY_VALID),
  .FAULT_EVT_STB(FAULT_EVT_STB), .SET_STB(SET_STB),
  .SET_OVER_LIMIT(SET_OVER_LIMIT), .SET_ACCEPT(SET_ACCEPT),
  .CAL_CMD_STB(CAL_CMD_STB), .CAL_MODE(CAL_MODE), .CAL_STORED(CAL_STORED),
  .POLL_ERR(POLL_ERR), .LIVE_STATUS(LIVE_STATUS)
);

// File: testbench/sfer_status_bench.sv
// Self-checking bench for the status block with a host model.
// Assumes answers one edge after each strobe, stores two edges after.
module sfer_status_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, nrst, ok;
  logic [12:0] cond, mask;
  logic [31:0] r;
  logic [15:0] lo, hi;
  int          miscompares, cmp_count, a, b, seed;
  int          codes [7] = '{4, 5, 6, 7, 8, 9, 10};
  int          exp_q [$];
  wire         q_stb, rv, e_stb, s_stb, s_over, acc, m_stb, m_val;
  wire         c_stb, mode, stored, perr;
  wire [2:0]   q_sel, e_sel, c_sel;
  wire [12:0]  rdata, live;
  wire [15:0]  c_lo, c_hi, k_lo, k_hi;
  sfer_status #(.DW(16)) dut (
    .CLK(clk), .NRST(nrst), .CONST_VOLT_FLAG(cond[0]),
    .CONST_CURR_FLAG(cond[1]), .OVERVOLTAGE_TRIP_FLAG(cond[3]),
    .OVERTEMP_TRIP_FLAG(cond[4]), .EXT_SHUTDOWN_FLAG(cond[5]),
    .FOLDBACK_FLAG(cond[6]), .POWER_ON_FLAG(cond[8]),
    .REMOTE_MODE_FLAG(cond[9]), .MAINS_FAIL_FLAG(cond[10]),
    .OUTPUT_FAIL_FLAG(cond[11]), .SENSE_TRIP_FLAG(cond[12]),
    .COND_MASK(mask), .QUERY_STB(q_stb), .QUERY_SEL(q_sel),
    .REPLY_DATA(rdata), .REPLY_VALID(rv), .FAULT_EVT_STB(e_stb),
    .FAULT_EVT_SEL(e_sel), .SET_STB(s_stb), .SET_OVER_LIMIT(s_over),
    .SET_ACCEPT(acc), .CAL_MODE_STB(m_stb), .CAL_MODE_VAL(m_val),
    .CAL_CMD_STB(c_stb), .CAL_CMD_SEL(c_sel), .CAL_VAL_LO(c_lo),
    .CAL_VAL_HI(c_hi), .CAL_MODE(mode), .CAL_CONST_LO(k_lo),
    .CAL_CONST_HI(k_hi), .CAL_STORED(stored), .POLL_ERR(perr),
    .LIVE_STATUS(live)
  );
  sfer_host u_host (
    .clk(clk), .rvalid(rv), .stored(stored), .q_stb(q_stb), .q_sel(q_sel),
    .e_stb(e_stb), .e_sel(e_sel), .s_stb(s_stb), .s_over(s_over),
    .m_stb(m_stb), .m_val(m_val), .c_stb(c_stb), .c_sel(c_sel),
    .c_lo(c_lo), .c_hi(c_hi)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // A reply that never comes ends the run
  task automatic ask(input logic [2:0] sel);
    u_host.query(sel);
    if (u_host.hung) begin
      miscompares++;
      final_report();
    end
  endtask
  initial begin
    {nrst, cond, mask, miscompares, cmp_count} = '0;
    seed = $urandom(30);
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    check({3'h0, live}, 16'h0000);
    // Two condition sets per round, so accumulation differs from live
    for (int i = 0; i < 8; i++) begin
      cond = 13'h0000;
      r = $urandom;
      mask = r[12:0];
      repeat (5) @(negedge clk);
      ask(3'h0);
      ask(3'h2);
      a = $urandom & 32'h1F7B;
      b = $urandom & 32'h1F7B;
      cond = a[12:0];
      repeat (5) @(negedge clk);
      cond = b[12:0];
      repeat (5) @(negedge clk);
      ask(3'h1);
      check({3'h0, rdata}, 16'(b & mask));
      ask(3'h2);
      check({3'h0, rdata}, 16'((a | b) & mask & 'h1CFF));
      ask(3'h0);
      check({3'h0, rdata}, 16'((a | b) & mask));
      ask(3'h0);
      check({3'h0, rdata}, 16'(b & mask));
    end
    $display("test conditions done");
    mask = 13'h1FFF;
    cond = 13'h0000;
    for (int i = 0; i < 7; i++) begin
      u_host.event_req(3'(i));
      exp_q.push_back(codes[i]);
      repeat (2) @(negedge clk);
      check({15'h0, live[7]}, 16'h0001);
      check({15'h0, perr}, 16'h0001);
      ask(3'h3);
      check({3'h0, rdata}, 16'(exp_q.pop_front()));
      check({15'h0, perr}, 16'h0000);
      ask(3'h3);
      check({3'h0, rdata}, 16'h0000);
    end
    u_host.setting(1'b1);
    check({15'h0, acc}, 16'h0000);
    ask(3'h3);
    check({3'h0, rdata}, 16'h0006);
    u_host.setting(1'b0);
    check({15'h0, acc}, 16'h0001);
    ask(3'h4);
    ask(3'h3);
    check({3'h0, rdata}, 16'h0008);
    $display("test error codes done");
    u_host.cal_mode(1'b1);
    check({15'h0, mode}, 16'h0001);
    r = $urandom;
    lo = r[15:0];
    hi = r[31:16];
    u_host.prog_cal(lo, hi, ok);
    check({15'h0, ok}, 16'h0001);
    check(k_lo, lo);
    check(k_hi, hi);
    u_host.rb_cal(hi, lo, ok);
    check({15'h0, ok}, 16'h0001);
    check(k_lo, hi);
    check(k_hi, lo);
    u_host.cal(3'h5, lo, hi, ok);
    check({15'h0, ok}, 16'h0000);
    ask(3'h3);
    check({3'h0, rdata}, 16'h0004);
    u_host.cal_mode(1'b0);
    u_host.cal(3'h0, lo, hi, ok);
    check({15'h0, ok}, 16'h0000);
    ask(3'h3);
    check({3'h0, rdata}, 16'h000C);
    $display("test calibration done");
    final_report();
  end
endmodule
